// ===== common/mcfg_pkg.sv
// Function
// - FEC bit enables coded, interleaved payload
// - Preamble code selects minimum preamble byte count
// - Channel offset from spacing mantissa, exponent, channel
// - FSK deviation from deviation mantissa and exponent
// - MSK uses mantissa as phase change fraction
// - Rx timeout is event period shifted down
// - Wake duty cycle halves per timeout code
// - Timer expiry keeps rx on sync or quality
// - Signal strength bit ends rx without carrier
`default_nettype none
package mcfg_pkg;

  // Register port geometry
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [5:0] ADDR_FEC_PREAMBLE   = 6'h13;
  localparam logic [5:0] ADDR_CHANNEL_NUMBER_SPACING   = 6'h14;
  localparam logic [5:0] ADDR_DEVIATION      = 6'h15;
  localparam logic [5:0] ADDR_RX_TIMEOUT     = 6'h16;

  // Values after reset
  localparam logic [7:0] RST_FEC_PREAMBLE    = 8'h22;
  localparam logic [7:0] RST_CHANNEL_NUMBER_SPACING    = 8'hF8;
  localparam logic [7:0] RST_DEVIATION       = 8'h47;
  localparam logic [7:0] RST_RX_TIMEOUT      = 8'h07;

  // Writable bits; the rest are reserved
  localparam logic [7:0] WMASK_FEC_PREAMBLE  = 8'hF3;
  localparam logic [7:0] WMASK_CHANNEL_NUMBER_SPACING  = 8'hFF;
  localparam logic [7:0] WMASK_DEVIATION     = 8'h77;
  localparam logic [7:0] WMASK_RX_TIMEOUT    = 8'h1F;

  // Field positions
  localparam int unsigned FEC_BIT            = 7;
  localparam int unsigned PREAMBLE_LSB       = 4;
  localparam int unsigned SPACING_EXP_LSB    = 0;
  localparam int unsigned DEV_EXP_LSB        = 4;
  localparam int unsigned DEV_MANT_LSB       = 0;
  localparam int unsigned RSSI_TERM_BIT      = 4;
  localparam int unsigned QUAL_BIT           = 3;
  localparam int unsigned RX_TIME_LSB        = 0;

  // Arithmetic constants
  localparam logic [8:0] SPACING_IMPLICIT    = 9'h100;
  localparam logic [3:0] DEV_IMPLICIT        = 4'h8;
  localparam logic [2:0] RX_TIME_NONE        = 3'h7;
  localparam logic [3:0] RX_TIME_BASE_SHIFT  = 4'h3;
  localparam logic [3:0] ASK_CS_SYMBOLS      = 4'h8;

  // Preamble byte count per code 0..7
  localparam logic [7:0][4:0] PREAMBLE_BYTES = {
    5'h18, 5'h10, 5'h0C, 5'h08, 5'h06, 5'h04, 5'h03, 5'h02
  };

endpackage
`default_nettype wire

// ===== core/mcfg_channel_number_calc.sv
`timescale 1ns/1ps
`default_nettype none
module mcfg_channel_number_calc
  import mcfg_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // Spacing fields and channel
  input  wire logic [7:0]  i_mantissa,
  input  wire logic [1:0]  i_exponent,
  input  wire logic [7:0]  i_channel_number,
  // Offset in units of crystal / 2^18
  output logic      [19:0] o_channel_offset
);

  typedef struct packed {
    logic [19:0] offset;
  } mcfg_channel_number_state_t;

  mcfg_channel_number_state_t state_q;
  mcfg_channel_number_state_t state_d;
  logic [11:0]      spacing_w;

  // Spacing word with implicit leading one, scaled by exponent
  always_comb begin
    spacing_w        = 12'({3'h0, SPACING_IMPLICIT + {1'b0, i_mantissa}} << i_exponent);
    state_d          = state_q;
    // Both factors widened first so the product keeps all twenty bits
    state_d.offset   = {8'h00, spacing_w} * {12'h000, i_channel_number};
  end

  // Registered so the product leaves on a flop
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_channel_offset = state_q.offset;

endmodule
`default_nettype wire

// ===== core/mcfg_dev_calc.sv
`timescale 1ns/1ps
`default_nettype none
module mcfg_dev_calc
  import mcfg_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // Deviation fields and modulation
  input  wire logic [2:0]  i_mantissa,
  input  wire logic [2:0]  i_exponent,
  input  wire logic        i_msk_mode,
  // Results
  output logic      [10:0] o_deviation_word,
  output logic      [2:0]  o_phase_change_fraction
);

  typedef struct packed {
    logic [10:0] dev;
    logic [2:0]  frac;
  } mcfg_dev_state_t;

  mcfg_dev_state_t state_q;
  mcfg_dev_state_t state_d;

  // Mantissa means deviation or phase fraction, never both
  always_comb begin
    state_d = state_q;
    if (i_msk_mode) begin
      state_d.dev  = '0;
      state_d.frac = i_mantissa;
    end else begin
      state_d.dev  = 11'({7'h0, DEV_IMPLICIT + {1'b0, i_mantissa}} << i_exponent);
      state_d.frac = '0;
    end
  end

  // Output flops
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_deviation_word        = state_q.dev;
  assign o_phase_change_fraction = state_q.frac;

endmodule
`default_nettype wire

// ===== core/mcfg_top.sv
`timescale 1ns/1ps
`default_nettype none
module mcfg_top
  import mcfg_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,

  // Register port, same clock domain as the core
  input  wire logic [5:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  output logic             o_reg_rvalid,

  // Radio context from neighbouring logic
  input  wire logic [7:0]  i_channel_number,
  input  wire logic        i_msk_mode,
  input  wire logic        i_ask_mode,
  input  wire logic [1:0]  i_wake_resolution,
  input  wire logic [15:0] i_wake_event_period,

  // Receive path events
  input  wire logic        i_rx_start,
  input  wire logic        i_end_of_packet,
  input  wire logic        i_sync_found,
  input  wire logic        i_preamble_quality_indicator,
  input  wire logic        i_carrier_sense,
  input  wire logic        i_cs_valid,
  input  wire logic        i_symbol_tick,

  // Modem configuration outputs
  output logic             o_error_correction_enable,
  output logic      [4:0]  o_preamble_bytes,
  output logic      [19:0] o_channel_offset,
  output logic      [10:0] o_deviation_word,
  output logic      [2:0]  o_phase_change_fraction,

  // Receive timeout outputs
  output logic             o_rx_active,
  output logic             o_rx_end,
  output logic             o_rx_timed_out,
  output logic      [3:0]  o_wor_duty_shift,
  output logic             o_wor_duty_valid
);

  // Receive control states
  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_TIMED = 3'b010,
    RX_HOLD  = 3'b100
  } mcfg_rx_st_t;

  // Whole module state in one word
  typedef struct packed {
    mcfg_rx_st_t rx_st;
    logic [7:0]  fec_pre;
    logic [7:0]  spacing;
    logic [7:0]  deviation;
    logic [7:0]  rx_ctrl;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [15:0] timer;
    logic [3:0]  sym_cnt;
    logic        cs_open;
    logic        sync_seen;
    logic        rx_end;
    logic        timed_out;
    logic        fec;
    logic [4:0]  pre_bytes;
    logic [3:0]  duty_shift;
    logic        duty_valid;
  } mcfg_state_t;

  mcfg_state_t state_q;
  mcfg_state_t state_d;

  // Field views of the stored registers
  logic [2:0]  rx_time_w;
  logic        qual_w;
  logic        rssi_term_w;
  logic [2:0]  pre_code_w;
  logic [3:0]  shift_w;
  logic [15:0] shifted_w;
  logic [15:0] timeout_w;
  logic        keep_w;
  logic        cs_fail_w;
  logic [3:0]  sym_next_w;

  assign rx_time_w   = state_q.rx_ctrl[RX_TIME_LSB +: 3];
  assign qual_w      = state_q.rx_ctrl[QUAL_BIT];
  assign rssi_term_w = state_q.rx_ctrl[RSSI_TERM_BIT];
  assign pre_code_w  = state_q.fec_pre[PREAMBLE_LSB +: 3];

  // Shift gives both timeout divisor and duty cycle exponent
  assign shift_w   = {1'b0, rx_time_w} + RX_TIME_BASE_SHIFT + {2'b00, i_wake_resolution};
  assign shifted_w = i_wake_event_period >> shift_w;

  // A zero-length window would never arm; clamp to one cycle
  assign timeout_w = (shifted_w == 16'h0000) ? 16'h0001 : shifted_w;

  // Expiry keeps rx if sync seen, or quality when qualified
  assign keep_w = state_q.sync_seen | i_sync_found
                | (qual_w & i_preamble_quality_indicator);

  // Carrier decision: ASK counts symbols, others use detector strobe
  assign sym_next_w = state_q.sym_cnt + 4'h1;
  always_comb begin
    cs_fail_w = 1'b0;
    if (state_q.cs_open) begin
      if (i_ask_mode) begin
        if (i_symbol_tick && (sym_next_w == ASK_CS_SYMBOLS)) begin
          cs_fail_w = ~i_carrier_sense;
        end
      end else if (i_cs_valid) begin
        cs_fail_w = ~i_carrier_sense;
      end
    end
  end

  // Next state
  always_comb begin
    state_d           = state_q;
    state_d.rx_end    = 1'b0;
    state_d.timed_out = 1'b0;
    state_d.rvalid    = 1'b0;

    // Writes keep only defined bits
    if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_FEC_PREAMBLE: begin
          state_d.fec_pre = i_reg_wdata & WMASK_FEC_PREAMBLE;
        end
        ADDR_CHANNEL_NUMBER_SPACING: begin
          state_d.spacing = i_reg_wdata & WMASK_CHANNEL_NUMBER_SPACING;
        end
        ADDR_DEVIATION: begin
          state_d.deviation = i_reg_wdata & WMASK_DEVIATION;
        end
        ADDR_RX_TIMEOUT: begin
          state_d.rx_ctrl = i_reg_wdata & WMASK_RX_TIMEOUT;
        end
        default: begin
        end
      endcase
    end

    // Reads answer one cycle later; unmapped reads return zero
    if (i_reg_rd) begin
      state_d.rvalid = 1'b1;
      case (i_reg_addr)
        ADDR_FEC_PREAMBLE: begin
          state_d.rdata = state_q.fec_pre;
        end
        ADDR_CHANNEL_NUMBER_SPACING: begin
          state_d.rdata = state_q.spacing;
        end
        ADDR_DEVIATION: begin
          state_d.rdata = state_q.deviation;
        end
        ADDR_RX_TIMEOUT: begin
          state_d.rdata = state_q.rx_ctrl;
        end
        default: begin
          state_d.rdata = 8'h00;
        end
      endcase
    end

    // Decoded configuration, one cycle behind the register
    state_d.fec        = state_q.fec_pre[FEC_BIT];
    state_d.pre_bytes  = PREAMBLE_BYTES[pre_code_w];
    state_d.duty_shift = shift_w;
    state_d.duty_valid = (rx_time_w != RX_TIME_NONE);

    // Symbol counting for the ASK carrier window
    if (state_q.cs_open && i_ask_mode && i_symbol_tick) begin
      state_d.sym_cnt = sym_next_w;
      if (sym_next_w == ASK_CS_SYMBOLS) begin
        state_d.cs_open = 1'b0;
      end
    end
    if (state_q.cs_open && !i_ask_mode && i_cs_valid) begin
      state_d.cs_open = 1'b0;
    end

    // Sync is sticky for the whole reception
    if (i_sync_found) begin
      state_d.sync_seen = 1'b1;
    end

    // Receive timeout sequencing
    unique case (state_q.rx_st)
      RX_IDLE: begin
        if (i_rx_start) begin
          state_d.sync_seen = i_sync_found;
          state_d.sym_cnt   = 4'h0;
          state_d.cs_open   = rssi_term_w;
          state_d.timer     = timeout_w;
          if (rx_time_w == RX_TIME_NONE) begin
            state_d.rx_st = RX_HOLD;
          end else begin
            state_d.rx_st = RX_TIMED;
          end
        end else begin
          state_d.cs_open = 1'b0;
        end
      end
      RX_TIMED: begin
        if (i_end_of_packet) begin
          state_d.rx_end  = 1'b1;
          state_d.cs_open = 1'b0;
          state_d.rx_st   = RX_IDLE;
        end else if (cs_fail_w) begin
          state_d.rx_end  = 1'b1;
          state_d.cs_open = 1'b0;
          state_d.rx_st   = RX_IDLE;
        end else if (state_q.timer == 16'h0001) begin
          // Counter stops at one; expiry is decided on this edge
          if (keep_w) begin
            state_d.rx_st = RX_HOLD;
          end else begin
            state_d.rx_end    = 1'b1;
            state_d.timed_out = 1'b1;
            state_d.cs_open   = 1'b0;
            state_d.rx_st     = RX_IDLE;
          end
        end else begin
          state_d.timer = state_q.timer - 16'h0001;
        end
      end
      RX_HOLD: begin
        // No timer here: only packet end or carrier loss closes
        if (i_end_of_packet) begin
          state_d.rx_end  = 1'b1;
          state_d.cs_open = 1'b0;
          state_d.rx_st   = RX_IDLE;
        end else if (cs_fail_w) begin
          state_d.rx_end  = 1'b1;
          state_d.cs_open = 1'b0;
          state_d.rx_st   = RX_IDLE;
        end
      end
      // Illegal one-hot codes fall back to idle
      // Carrier window is closed so a stale check cannot fire
      default: begin
        state_d.rx_st   = RX_IDLE;
        state_d.cs_open = 1'b0;
      end
    endcase
  end

  // State register
  // Reset loads constants only, so the reset tree stays simple
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q            <= '0;
      state_q.rx_st      <= RX_IDLE;
      state_q.fec_pre    <= RST_FEC_PREAMBLE;
      state_q.spacing    <= RST_CHANNEL_NUMBER_SPACING;
      state_q.deviation  <= RST_DEVIATION;
      state_q.rx_ctrl    <= RST_RX_TIMEOUT;
      state_q.pre_bytes  <= PREAMBLE_BYTES[RST_FEC_PREAMBLE[PREAMBLE_LSB +: 3]];
      state_q.duty_shift <= {1'b0, RX_TIME_NONE} + RX_TIME_BASE_SHIFT;
    end else begin
      state_q <= state_d;
    end
  end

  // Channel offset product, kept apart for its multiplier
  mcfg_channel_number_calc u_channel_number (
    .i_clk            (i_clk),
    .i_nrst           (i_nrst),
    .i_mantissa       (state_q.spacing),
    .i_exponent       (state_q.fec_pre[SPACING_EXP_LSB +: 2]),
    .i_channel_number (i_channel_number),
    .o_channel_offset (o_channel_offset)
  );

  // Deviation or MSK phase fraction
  mcfg_dev_calc u_dev (
    .i_clk                   (i_clk),
    .i_nrst                  (i_nrst),
    .i_mantissa              (state_q.deviation[DEV_MANT_LSB +: 3]),
    .i_exponent              (state_q.deviation[DEV_EXP_LSB +: 3]),
    .i_msk_mode              (i_msk_mode),
    .o_deviation_word        (o_deviation_word),
    .o_phase_change_fraction (o_phase_change_fraction)
  );

  // Outputs straight from flops
  // Active is a decode of the state flop, free of glitches between codes
  assign o_reg_rdata               = state_q.rdata;
  assign o_reg_rvalid              = state_q.rvalid;
  assign o_error_correction_enable = state_q.fec;
  assign o_preamble_bytes          = state_q.pre_bytes;
  assign o_rx_active               = (state_q.rx_st != RX_IDLE);
  assign o_rx_end                  = state_q.rx_end;
  assign o_rx_timed_out            = state_q.timed_out;
  assign o_wor_duty_shift          = state_q.duty_shift;
  assign o_wor_duty_valid          = state_q.duty_valid;

endmodule
`default_nettype wire

// ===== tb/mcfg_host.sv
`timescale 1ns/1ps
`default_nettype none
module mcfg_host (
  // Clock
  input  wire logic       i_clk,
  // Register port toward the device
  output logic      [5:0] o_addr,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_wdata,
  // Device answer
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid
);
  // Idle bus at time zero
  initial begin
    o_addr  = 6'h3F;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_wdata = 8'h00;
  end

  // Full bytes, reserved bits too, so the device must mask them
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;  // Released lines never keep the last value
    o_wdata <= ~d;
  endtask

  // Read answer taken once the strobe edge has landed
  task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic v);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    @(negedge i_clk);
    d = i_rdata;
    v = i_rvalid;
  endtask
endmodule
`default_nettype wire

// ===== tb/mcfg_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mcfg_chk
  import mcfg_pkg::*;
(
  // Clock, reset and register port
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic [5:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic [7:0]  o_reg_rdata,
  input  wire logic        o_reg_rvalid,
  // Modem and receive side
  input  wire logic        i_msk_mode,
  input  wire logic        i_rx_start,
  input  wire logic        o_error_correction_enable,
  input  wire logic [4:0]  o_preamble_bytes,
  input  wire logic [10:0] o_deviation_word,
  input  wire logic        o_rx_active,
  input  wire logic        o_rx_end,
  input  wire logic        o_rx_timed_out,
  input  wire logic        o_wor_duty_valid
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  // Write strobes of the two registers watched here
  wire w13 = i_reg_wr && i_reg_addr == ADDR_FEC_PREAMBLE;
  wire w16 = i_reg_wr && i_reg_addr == ADDR_RX_TIMEOUT;

  // Readable bits per address; unmapped reads nothing
  function automatic logic [7:0] rmask(input logic [5:0] a);
    case (a)
      ADDR_FEC_PREAMBLE: rmask = WMASK_FEC_PREAMBLE;
      ADDR_CHANNEL_NUMBER_SPACING: rmask = WMASK_CHANNEL_NUMBER_SPACING;
      ADDR_DEVIATION:    rmask = WMASK_DEVIATION;
      ADDR_RX_TIMEOUT:   rmask = WMASK_RX_TIMEOUT;
      default:           rmask = 8'h00;
    endcase
  endfunction

  property p_fec;
    w13 |-> ##2 o_error_correction_enable == $past(i_reg_wdata[7], 2);
  endproperty
  a_fec: assert property (p_fec) else $error("fec flag wrong");
  property p_pre;
    w13 |-> ##2 o_preamble_bytes == PREAMBLE_BYTES[$past(i_reg_wdata[6:4], 2)];
  endproperty
  a_pre: assert property (p_pre) else $error("preamble count wrong");
  property p_msk;
    i_msk_mode [*3] |=> o_deviation_word == 11'h000;
  endproperty
  a_msk: assert property (p_msk) else $error("deviation in msk");
  property p_rd;
    i_reg_rd |=> o_reg_rvalid && (o_reg_rdata & ~rmask($past(i_reg_addr))) == 8'h00;
  endproperty
  a_rd: assert property (p_rd) else $error("reserved bits read");
  property p_start;
    i_rx_start && !o_rx_active |=> o_rx_active;
  endproperty
  a_start: assert property (p_start) else $error("rx not started");
  property p_end;
    o_rx_end |-> !o_rx_active && $past(o_rx_active);
  endproperty
  a_end: assert property (p_end) else $error("rx end while idle");
  property p_to;
    o_rx_timed_out |-> o_rx_end && o_wor_duty_valid;
  endproperty
  a_to: assert property (p_to) else $error("timeout without timer");
  property p_duty;
    w16 |-> ##2 o_wor_duty_valid == ($past(i_reg_wdata[2:0], 2) != RX_TIME_NONE);
  endproperty
  a_duty: assert property (p_duty) else $error("duty flag wrong");

  // Main scenarios reached
  c_to: cover property (o_rx_timed_out);
  c_keep: cover property (o_rx_end && !o_rx_timed_out);
  c_rd: cover property (o_reg_rvalid && o_reg_rdata != 8'h00);
endmodule

bind mcfg_top mcfg_chk i_chk (
  .i_clk, .i_nrst, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata,
  .o_reg_rvalid, .i_msk_mode, .i_rx_start, .o_error_correction_enable,
  .o_preamble_bytes, .o_deviation_word, .o_rx_active, .o_rx_end, .o_rx_timed_out,
  .o_wor_duty_valid
);
`default_nettype wire

// ===== tb/modem_and_rx_timeout_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
module modem_and_rx_timeout_config_bench import mcfg_pkg::*;;
  // Design pins, given values at time zero
  logic        i_clk;
  logic        i_nrst = 1'b0;
  logic [5:0]  i_reg_addr;
  logic        i_reg_wr, i_reg_rd, o_reg_rvalid;
  logic [7:0]  i_reg_wdata, o_reg_rdata;
  logic [7:0]  i_channel_number = 8'h00;
  logic        i_msk_mode = 1'b0, i_ask_mode = 1'b0;
  logic [1:0]  i_wake_resolution = 2'h0;
  logic [15:0] i_wake_event_period = 16'h0400;
  logic        i_rx_start = 1'b0, i_end_of_packet = 1'b0, i_sync_found = 1'b0;
  logic        i_preamble_quality_indicator = 1'b0, i_carrier_sense = 1'b0;
  logic        i_cs_valid = 1'b0, i_symbol_tick = 1'b0;
  logic        o_error_correction_enable, o_rx_active, o_rx_end, o_rx_timed_out;
  logic        o_wor_duty_valid;
  logic [4:0]  o_preamble_bytes;
  logic [19:0] o_channel_offset;
  logic [10:0] o_deviation_word;
  logic [2:0]  o_phase_change_fraction;
  logic [3:0]  o_wor_duty_shift;
  // Register model: contents, writable bits, preamble table
  int          rm[4] = '{8'h22, 8'hF8, 8'h47, 8'h07};
  int          wm[4] = '{8'hF3, 8'hFF, 8'h77, 8'h1F};
  int          pb[8] = '{2, 3, 4, 6, 8, 12, 16, 24};
  int          n_mismatch = 0;
  int          checked = 0;

  mcfg_top i_dut (
    .i_clk, .i_nrst, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata,
    .o_reg_rvalid, .i_channel_number, .i_msk_mode, .i_ask_mode, .i_wake_resolution,
    .i_wake_event_period, .i_rx_start, .i_end_of_packet, .i_sync_found,
    .i_preamble_quality_indicator, .i_carrier_sense, .i_cs_valid, .i_symbol_tick,
    .o_error_correction_enable, .o_preamble_bytes, .o_channel_offset, .o_deviation_word,
    .o_phase_change_fraction, .o_rx_active, .o_rx_end, .o_rx_timed_out,
    .o_wor_duty_shift, .o_wor_duty_valid
  );
  mcfg_host i_host (
    .i_clk, .o_addr(i_reg_addr), .o_wr(i_reg_wr), .o_rd(i_reg_rd),
    .o_wdata(i_reg_wdata), .i_rdata(o_reg_rdata), .i_rvalid(o_reg_rvalid)
  );

  // 100 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic chk(input string s, input int e, input logic [19:0] g);
    checked++;
    if (g !== 20'(e)) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", s, e, g);
    end
  endtask

  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Read one address and compare with the model
  task automatic rchk(input int a);
    logic [7:0] d;
    logic       v;
    i_host.rd(6'(a), d, v);
    chk("rvalid", 1, v);
    chk("rdata", (a > 18 && a < 23) ? rm[a - 19] : 0, d);
  endtask

  task automatic wchk(input int k, input logic [7:0] d);
    i_host.wr(ADDR_FEC_PREAMBLE + 6'(k), d);
    rm[k] = d & wm[k];
  endtask

  // Decoded outputs after the two-flop calc latency has passed
  task automatic cchk();
    int m;
    int x;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    m = rm[2] & 7;
    x = (rm[2] >> 4) & 7;
    chk("fec", rm[0][7], o_error_correction_enable);
    chk("preamble", pb[rm[0][6:4]], o_preamble_bytes);
    chk("offset", ((256 + rm[1]) << rm[0][1:0]) * i_channel_number, o_channel_offset);
    chk("deviation", i_msk_mode ? 0 : (8 + m) << x, o_deviation_word);
    chk("fraction", i_msk_mode ? m : 0, o_phase_change_fraction);
  endtask

  // One reception; sync, carrier and end of packet placed at fixed cycles
  // rs: 0 no carrier check, 1 check with carrier absent, 2 check with carrier present
  task automatic rx(input int c, sy, q, pq, rs, ak);
    int t, e, n, xn, xto;
    logic k;
    wchk(3, 8'((rs > 0) * 16 + q * 8 + c + 32));
    @(posedge i_clk);
    i_wake_resolution <= 2'($urandom);
    i_preamble_quality_indicator <= pq[0];
    i_ask_mode <= ak[0];
    i_carrier_sense <= rs[1];
    repeat (3) @(posedge i_clk);
    t = i_wake_event_period >> (c + 3 + i_wake_resolution);
    t = (t < 1) ? 1 : t;
    e = (c == 7) ? 300 : t + 5;
    xto = rs != 1 && c != 7 && !sy && !(q && pq);
    xn = (rs == 1) ? (ak ? 9 : 2) : (xto ? t : e);
    chk("duty_shift", c + 3 + i_wake_resolution, o_wor_duty_shift);
    chk("duty_valid", c != 7, o_wor_duty_valid);
    i_rx_start <= 1'b1;
    @(posedge i_clk);
    i_rx_start <= 1'b0;
    n = 0;
    k = 1'b0;
    while (k !== 1'b1 && n < 400) begin
      @(posedge i_clk);
      n++;
      i_sync_found <= sy && n == 1;
      i_cs_valid <= rs && !ak && n == 1;
      i_symbol_tick <= ak && n < 9;
      i_end_of_packet <= n == e - 1;
      @(negedge i_clk);
      k = o_rx_end;
    end
    chk("end_cycle", xn, 20'(n));
    chk("timed_out", xto, o_rx_timed_out);
    chk("active", 0, o_rx_active);
  endtask

  // Main sequence
  initial begin
    void'($urandom(22596));
    repeat (16) @(posedge i_clk);
    i_nrst <= 1'b1;
    cchk();
    for (int a = 18; a < 24; a++) rchk(a);
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clk);
      i_channel_number <= (i == 7) ? 8'hFF : 8'($urandom);
      i_msk_mode <= i[0];
      wchk(0, {1'($urandom), 3'(i), 4'($urandom)});
      wchk(1, 8'($urandom));
      wchk(2, 8'($urandom));
      cchk();
      for (int a = 19; a < 22; a++) rchk(a);
    end
    for (int c = 0; c < 8; c++) rx(c, 0, 0, 0, 0, 0);
    rx(0, 1, 0, 0, 0, 0);
    rx(1, 0, 0, 1, 0, 0);
    rx(1, 0, 1, 1, 0, 0);
    rx(2, 0, 1, 0, 0, 0);
    rx(7, 0, 0, 0, 1, 0);
    rx(7, 0, 0, 0, 1, 1);
    rx(7, 0, 0, 0, 2, 0);
    rx(7, 0, 0, 0, 2, 1);
    rchk(22);
    // Second reset in mid-run must bring every register back
    @(posedge i_clk);
    i_nrst <= 1'b0;
    rm = '{RST_FEC_PREAMBLE, RST_CHANNEL_NUMBER_SPACING, RST_DEVIATION, RST_RX_TIMEOUT};
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    cchk();
    for (int a = 19; a < 23; a++) rchk(a);
    stop_test();
  end

  // Whole run needs some two thousand cycles; forty thousand is a hang
  initial begin
    #400_000;
    n_mismatch++;
    stop_test();
  end
endmodule
`default_nettype wire
